// *** bench/edsp_mem_model.sv ***
// memory side model counting accesses
`timescale 1ns/1ps
module edsp_mem_model (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire edsp_pkg::edsp_acc_t acc, // access
	output logic [7:0] n_acc // count
);
	import edsp_pkg::*;
	always_ff @(posedge clk) begin
		if (!rstn) n_acc <= 8'h00;
		else if (acc.valid) n_acc <= n_acc + 8'h01;
	end
endmodule

// *** bench/edsp_monitor.sv ***
// checker on the pager ports
`timescale 1ns/1ps
`include "edsp_map.svh"
module edsp_monitor (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic ce, // enable
	input wire logic rd_page_we, // page load
	input wire edsp_pkg::edsp_req_t req, // request
	input wire logic req_ready, // taken
	input wire edsp_pkg::edsp_acc_t acc, // result
	input wire logic addr_err, // trap
	input wire logic [`EDSP_PAGE_W-1:0] rd_page, // read page
	input wire logic [`EDSP_PAGE_W-1:0] wr_page // write page
);
	import edsp_pkg::*;
	logic tk;
	logic [9:0] pg;
	assign tk = ce && req.valid && req_ready;
	assign pg = (req.write && !req.program_space_view) ? wr_page : rd_page;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_win; tk && req.addr[15] && pg != 10'h000; endsequence
	sequence s_rdw; ce && req.valid && !req.write && req.addr[15] && !req_ready; endsequence
	property p_rd_ea; s_win ##0 (!req.write || req.program_space_view) |=> acc.valid
		&& acc.ea == {$past(rd_page[8:0]), $past(req.addr[14:0])}; endproperty
	a_rd_ea: assert property (p_rd_ea) else $error("read address");
	property p_wr_ea; s_win ##0 (req.write && !req.program_space_view) |=> acc.valid
		&& acc.ea == {$past(wr_page[8:0]), $past(req.addr[14:0])}; endproperty
	a_wr_ea: assert property (p_wr_ea) else $error("write address");
	property p_low; tk && !req.addr[15] |=> acc.valid && acc.ea == {8'h00, $past(req.addr)};
	endproperty
	a_low: assert property (p_low) else $error("base address");
	property p_zero; tk && req.addr[15] && pg == 10'h000 |=> addr_err && !acc.valid; endproperty
	a_zero: assert property (p_zero) else $error("page zero");
	property p_wr1; ce && req.valid && req.write |-> req_ready; endproperty
	a_wr1: assert property (p_wr1) else $error("write stalled");
	property p_rd_ovh; s_rdw ##0 !req.repeat_on |=> !ce || req_ready; endproperty
	a_rd_ovh: assert property (p_rd_ovh) else $error("read overhead");
	property p_rpt; s_rdw ##0 req.repeat_on ##1 s_rdw |=> !ce || req_ready; endproperty
	a_rpt: assert property (p_rpt) else $error("repeat read");
	property p_hold; !rd_page_we |=> $stable(rd_page); endproperty
	a_hold: assert property (p_hold) else $error("page moved");
endmodule

// *** bench/tb_top.sv ***
// bench for the pager
`timescale 1ns/1ps
module tb_top;
	import edsp_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, rwe = 1'b0, wwe = 1'b0, ce = 1'b1, req_ready, addr_err;
	logic [9:0] pwd = 10'h000, rd_page, wr_page;
	logic [7:0] n_acc;
	edsp_req_t req = '0;
	edsp_acc_t acc;
	int errors = 0, checks = 0, n;
	edsp_pager u_edsp_pager (.clk(clk), .rstn(rstn), .ce(ce), .rd_page_we(rwe),
		.wr_page_we(wwe), .page_wdata(pwd), .req(req), .req_ready(req_ready), .acc(acc),
		.addr_err(addr_err), .rd_page(rd_page), .wr_page(wr_page));
	edsp_mem_model u_edsp_mem_model (.clk(clk), .rstn(rstn), .acc(acc), .n_acc(n_acc));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic setp(logic r, logic [9:0] v);
		@(posedge clk);
		pwd <= v;
		rwe <= r;
		wwe <= !r;
		@(posedge clk);
		rwe <= 1'b0;
		wwe <= 1'b0;
	endtask
	task automatic go(logic w, logic p, logic rp, logic [15:0] a, logic [23:0] ea, int c, logic er);
		@(posedge clk);
		req <= '{1'b1, w, p, rp, a};
		#1;
		n = 1;
		while (!req_ready && n < 9) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 9) begin
			errors++;
			wrap_up();
		end
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		chk("cycles", c, n);
		chk("trap", er, addr_err);
		chk("valid", !er, acc.valid);
		if (!er) chk("ea", ea, acc.ea);
		if (!er) chk("write", w, acc.write);
		if (!er) chk("psv", p && !w, acc.program_space_view);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		chk("pages", 20'h00401, {rd_page, wr_page});
		@(posedge clk);
		ce <= 1'b0;
		pwd <= 10'h155;
		rwe <= 1'b1;
		@(posedge clk);
		rwe <= 1'b0;
		ce <= 1'b1;
		#1;
		chk("frozen", 10'h001, rd_page);
		setp(1'b1, 10'h002);
		go(1'b0, 1'b0, 1'b0, 16'h8800, 24'h010800, 2, 1'b0);
		chk("space", 1'b0, acc.ext_space);
		setp(1'b0, 10'h003);
		go(1'b1, 1'b0, 1'b0, 16'h8010, 24'h018010, 1, 1'b0);
		go(1'b0, 1'b1, 1'b0, 16'hffff, 24'h017fff, 2, 1'b0);
		go(1'b0, 1'b0, 1'b0, 16'h1234, 24'h001234, 1, 1'b0);
		setp(1'b0, 10'h000);
		go(1'b1, 1'b0, 1'b0, 16'h8000, 24'h000000, 1, 1'b1);
		setp(1'b1, 10'h001);
		go(1'b0, 1'b0, 1'b1, 16'h8000, 24'h008000, 3, 1'b0);
		go(1'b0, 1'b0, 1'b1, 16'h8002, 24'h008002, 3, 1'b0);
		go(1'b0, 1'b0, 1'b1, 16'h8004, 24'h008004, 1, 1'b0);
		setp(1'b1, 10'h201);
		go(1'b0, 1'b0, 1'b0, 16'h8000, 24'h008000, 2, 1'b0);
		chk("space", 1'b1, acc.ext_space);
		@(posedge clk);
		#1;
		chk("accesses", 32'h8, n_acc);
		wrap_up();
	end
endmodule
bind edsp_pager edsp_monitor u_edsp_monitor (.clk(clk), .rstn(rstn), .ce(ce),
	.rd_page_we(rd_page_we), .req(req), .req_ready(req_ready), .acc(acc),
	.addr_err(addr_err), .rd_page(rd_page), .wr_page(wr_page));

// *** include/edsp_map.svh ***
// address map constants and timing counts for the extended data space pager
`ifndef EDSP_MAP_SVH
`define EDSP_MAP_SVH

// ==========================================================
// address layout
`define EDSP_DADDR_W 16
`define EDSP_EA_W 24
`define EDSP_PAGE_W 10
`define EDSP_CAT_W 9
`define EDSP_OFS_W 15
`define EDSP_WIN_BIT 15
`define EDSP_SPACE_BIT 9
`define EDSP_WIN_BYTES 32768
`define EDSP_PAGE_RST 10'h001

// ==========================================================
// cycle counts
`define EDSP_RD_CYC 2
`define EDSP_RPT_FIRST_CYC 3
`define EDSP_RPT_FIRST_N 2
`define EDSP_WR_CYC 1

`endif

// *** include/edsp_pkg.sv ***
// types shared by the extended data space pager
`include "edsp_map.svh"
package edsp_pkg;
	// access request from the address generators
	typedef struct packed {
		logic valid;
		logic write;
		logic program_space_view;
		logic repeat_on;
		logic [`EDSP_DADDR_W-1:0] addr;
	} edsp_req_t;

	// translated access toward the memory spaces
	typedef struct packed {
		logic valid;
		logic write;
		logic ext_space;
		logic program_space_view;
		logic [`EDSP_EA_W-1:0] ea;
	} edsp_acc_t;

	typedef enum logic [1:0] {
		EDSP_IDLE,
		EDSP_WAIT
	} edsp_state_t;
endpackage

// *** src/edsp_pager.sv ***
// extended data space address translation, page-zero trap and read cycle timing
`timescale 1ns/1ps
`include "edsp_map.svh"

// What this block does
// - pages equal one 32-Kbyte window
// - reads use read page, writes write page
// - program space view uses read page only
// - page plus 16-bit address gives 24-bit address
// - page zero in window raises address error
// - read: nine page bits above 15 offset bits
// - extended read costs one extra cycle
// - repeated reads: first two three cycles, then one
// - write: nine page bits above 15 offset bits
// - below 8000h page registers are ignored
// - extended writes complete in one cycle
module edsp_pager (
	input wire logic clk, // 40 MHz instruction clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic rd_page_we, // load read page select
	input wire logic wr_page_we, // load write page select
	input wire logic [`EDSP_PAGE_W-1:0] page_wdata, // page value to load
	input wire edsp_pkg::edsp_req_t req, // access request
	output logic req_ready, // request taken this cycle
	output edsp_pkg::edsp_acc_t acc, // translated access, registered
	output logic addr_err, // address error trap pulse, registered
	output logic [`EDSP_PAGE_W-1:0] rd_page, // read page select value
	output logic [`EDSP_PAGE_W-1:0] wr_page // write page select value
);
	import edsp_pkg::*;

	// ==========================================================
	// address forming
	function automatic logic [`EDSP_EA_W-1:0] form_ea(
		input logic [`EDSP_PAGE_W-1:0] page,
		input logic [`EDSP_DADDR_W-1:0] addr
	);
		logic [`EDSP_EA_W-1:0] ea;
		ea = '0;
		if (addr[`EDSP_WIN_BIT]) begin
			ea = {page[`EDSP_CAT_W-1:0], addr[`EDSP_OFS_W-1:0]};
		end else begin
			ea = {8'h00, addr};
		end
		return ea;
	endfunction

	logic [`EDSP_PAGE_W-1:0] rd_page_q;
	logic [`EDSP_PAGE_W-1:0] wr_page_q;
	edsp_state_t state_q;
	logic [1:0] wait_q;
	logic [1:0] rpt_cnt_q;
	edsp_acc_t acc_q;
	logic err_q;

	logic in_win;
	logic [`EDSP_PAGE_W-1:0] sel_page;
	logic page_zero;
	logic [1:0] extra;
	logic trap_hit;
	logic hold_off;

	// ==========================================================
	// page select registers
	// pages change only on explicit loads; pointer wrap never touches them
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_page_q <= `EDSP_PAGE_RST;
			wr_page_q <= `EDSP_PAGE_RST;
		end else if (ce) begin
			if (rd_page_we) begin
				rd_page_q <= page_wdata;
			end
			if (wr_page_we) begin
				wr_page_q <= page_wdata;
			end
		end
	end

	assign rd_page = rd_page_q;
	assign wr_page = wr_page_q;

	// ==========================================================
	// page selection and trap detection
	assign in_win = req.addr[`EDSP_WIN_BIT];
	always_comb begin
		if (req.write && !req.program_space_view) begin
			sel_page = wr_page_q;
		end else begin
			sel_page = rd_page_q;
		end
	end
	assign page_zero = (sel_page == '0);

	// extra wait cycles a read needs before it completes
	always_comb begin
		extra = 2'd0;
		if (req.write || !in_win) begin
			extra = 2'd0;
		end else if (req.repeat_on && rpt_cnt_q < 2'(`EDSP_RPT_FIRST_N)) begin
			extra = 2'(`EDSP_RPT_FIRST_CYC - 1);
		end else if (req.repeat_on) begin
			extra = 2'd0;
		end else begin
			extra = 2'(`EDSP_RD_CYC - 1);
		end
	end

	// ==========================================================
	// request acceptance
	// a trapped window access never waits: the trap is reported at once
	assign trap_hit = in_win && page_zero;

	// a fresh read that needs wait cycles is held off until its last cycle,
	// so the requester keeps its request standing through the overhead
	always_comb begin
		hold_off = 1'b0;
		if (state_q == EDSP_IDLE) begin
			hold_off = req.valid && extra != 2'd0 && !trap_hit;
		end else if (wait_q != 2'd1) begin
			hold_off = 1'b1;
		end
	end

	// writes and base-space accesses see ready straight away
	assign req_ready = ce && !hold_off;

	// ==========================================================
	// access timing
	// ready is asserted on the final cycle, so the output lands on completion
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= EDSP_IDLE;
			wait_q <= 2'd0;
		end else if (ce) begin
			case (state_q)
			EDSP_IDLE: begin
				if (req.valid && extra != 2'd0 && !(page_zero && in_win)) begin
					state_q <= EDSP_WAIT;
					wait_q <= extra;
				end
			end
			EDSP_WAIT: begin
				if (wait_q == 2'd1) begin
					state_q <= EDSP_IDLE;
					wait_q <= 2'd0;
				end else begin
					wait_q <= wait_q - 2'd1;
				end
			end
			default: begin
				state_q <= EDSP_IDLE;
			end
			endcase
		end
	end

	// counts window reads under repeat; cleared once repeat drops
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rpt_cnt_q <= 2'd0;
		end else if (ce) begin
			if (!req.repeat_on) begin
				rpt_cnt_q <= 2'd0;
			end else if (req_ready && req.valid && !req.write && in_win
				&& rpt_cnt_q < 2'(`EDSP_RPT_FIRST_N)) begin
				rpt_cnt_q <= rpt_cnt_q + 2'd1;
			end
		end
	end

	// ==========================================================
	// translated access output
	always_ff @(posedge clk) begin
		if (!rstn) begin
			acc_q <= '0;
			err_q <= 1'b0;
		end else if (ce) begin
			acc_q <= '0;
			err_q <= 1'b0;
			if (req_ready && req.valid) begin
				if (in_win && page_zero) begin
					err_q <= 1'b1;
				end else begin
					acc_q.valid <= 1'b1;
					acc_q.write <= req.write;
					acc_q.program_space_view <= req.program_space_view && !req.write;
					// bit 9 high routes to another space, not the data pages
					acc_q.ext_space <= in_win && sel_page[`EDSP_SPACE_BIT];
					acc_q.ea <= form_ea(sel_page, req.addr);
				end
			end
		end
	end

	assign acc = acc_q;
	assign addr_err = err_q;
endmodule
